// ===== logic/pmc_defs.svh
// Purpose: constants for the power mode controller
// Assumes: 32-bit avalon-mm word registers
// Notes: byte offsets
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH
`define PMC_OFF_CTL_A 4'h0
`define PMC_OFF_CTL_B 4'h4
`define PMC_OFF_REG 4'h8
`define PMC_OFF_STATUS 4'hc
`define PMC_OFF_PCLK 4'h0
`define PMC_BIT_IDLE 0
`define PMC_BIT_STOP 1
`define PMC_BIT_SUSPEND 0
`define PMC_BIT_SNOOZE 1
`define PMC_BIT_DEEP_OFF 0
`define PMC_BIT_CLK_FAST_A 1
`define PMC_NUM_PERIPH 8
`define PMC_NUM_WAKE 6
`define PMC_DIV_SLOW 3'h7
`define PMC_PCLK_RESET 8'hff
`endif

// ===== logic/pmc_pkg.sv
// Purpose: types for the power mode controller
// Assumes: nothing
// Notes: one-hot modes
package pmc_pkg;
    typedef enum logic [5:0] {
        PMC_NORMAL = 6'b00_0001,
        PMC_IDLE = 6'b00_0010,
        PMC_SUSPEND = 6'b00_0100,
        PMC_SNOOZE = 6'b00_1000,
        PMC_STOP = 6'b01_0000,
        PMC_SHUTDOWN = 6'b10_0000
    } pmc_mode_e;
endpackage

// ===== logic/pmc_sync.sv
// Purpose: three-stage synchroniser with agreement check
// Assumes: i_mclk domain
// Notes: change counted when stages two and three agree
`timescale 1ns/1ps
`include "pmc_defs.svh"
module pmc_sync (
    input wire logic i_mclk, // clock
    input wire logic i_reset, // async reset
    input wire logic [`PMC_NUM_WAKE-1:0] i_async, // raw inputs
    output logic [`PMC_NUM_WAKE-1:0] o_sync // filtered level
);
    logic [`PMC_NUM_WAKE-1:0] s1_r;
    logic [`PMC_NUM_WAKE-1:0] s2_r;
    logic [`PMC_NUM_WAKE-1:0] s3_r;
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            o_sync <= '0;
        end else begin
            s1_r <= i_async;
            s2_r <= s1_r;
            s3_r <= s2_r;
            for (int k = 0; k < `PMC_NUM_WAKE; k++) begin
                if (s2_r[k] == s3_r[k]) begin
                    o_sync[k] <= s3_r[k];
                end
            end
        end
    end
endmodule // pmc_sync

// ===== logic/pmc_top.sv
// Purpose: power mode controller with avalon-mm register slave
// Assumes: 20 MHz i_mclk, software follows entry sequences
// Notes: slow clock input sampled, timer enable pulses on slow/8
// What this block does
// - normal mode: core and every enabled peripheral clocked
// - idle request bit halts core, peripherals keep running
// - idle ends on interrupt; wakes resume code, no restart
// - suspend: clocks halted, fast oscs off, regulator normal bias
// - snooze: clocks halted, fast oscs off, regulator low bias
// - suspend and snooze leave on any of six wake sources
// - timers 3 and 4 may tick from slow osc divided by eight
// - stop powers down nets, pins hold, any reset ends it
// - shutdown ends only on reset pin or power-on reset
// - unused digital peripherals get their clocks gated off
//
// Chosen here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "pmc_defs.svh"
module pmc_top (
    input wire logic i_mclk, // system clock
    input wire logic i_reset, // async reset, high
    input wire logic [3:0] i_avs_address, // byte address
    input wire logic i_avs_read, // read strobe
    input wire logic i_avs_write, // write strobe
    input wire logic [31:0] i_avs_writedata, // write data
    input wire logic [3:0] i_avs_byteenable, // byte lanes
    output logic [31:0] o_avs_readdata, // read data
    output logic o_avs_waitrequest, // wait
    input wire logic i_irq_any, // any pending interrupt
    input wire logic [`PMC_NUM_WAKE-1:0] i_wake, // async wake sources
    input wire logic i_any_reset_src, // any reset source, level
    input wire logic i_reset_pin_n, // external reset pin, low active
    input wire logic i_por, // power-on reset, high
    input wire logic i_slow_osc, // slow oscillator level
    output logic o_core_clk_en, // core clock enable
    output logic [`PMC_NUM_PERIPH-1:0] o_periph_clk_en, // peripheral clock enables
    output logic o_fast_osc_a_en, // fast osc a running
    output logic o_fast_osc_b_en, // fast osc b running
    output logic o_reg_low_bias, // regulator low bias
    output logic o_power_off, // internal nets off
    output logic o_pin_hold, // pins retain state
    output logic o_wake_sel, // wake sources armed
    output logic o_timer_tick, // slow/8 tick for timers 3 and 4
    output logic [5:0] o_mode // current mode one-hot
);
    pmc_pkg::pmc_mode_e mode_r;
    pmc_pkg::pmc_mode_e mode_nxt;
    logic idle_req_r;
    logic stop_req_r;
    logic suspend_req_r;
    logic snooze_req_r;
    logic deep_off_select_r;
    logic clk_fast_a_r;
    logic [`PMC_NUM_PERIPH-1:0] pclk_r;
    logic [`PMC_NUM_WAKE-1:0] wake_s;
    // synchronised levels: por, reset source, reset pin, slow osc
    logic [3:0] misc_s1_r;
    logic [3:0] misc_s2_r;
    logic [3:0] misc_s3_r;
    logic [3:0] misc_r;
    // slow clock divider for the timer tick
    logic slow_prev_r;
    logic [2:0] div_r;
    // bus handshake and decoded strobes
    logic ack_r;
    logic wake_hit;
    logic leave;
    logic wr;
    logic rd;

    // mode groups for the output registers; awake and off are shared by several, asleep feeds o_wake_sel only
    function automatic logic fn_awake(input pmc_pkg::pmc_mode_e m);
        return (m == pmc_pkg::PMC_NORMAL) || (m == pmc_pkg::PMC_IDLE);
    endfunction

    function automatic logic fn_off(input pmc_pkg::pmc_mode_e m);
        return (m == pmc_pkg::PMC_STOP) || (m == pmc_pkg::PMC_SHUTDOWN);
    endfunction

    function automatic logic fn_asleep(input pmc_pkg::pmc_mode_e m);
        return (m == pmc_pkg::PMC_SUSPEND) || (m == pmc_pkg::PMC_SNOOZE);
    endfunction

    pmc_sync u_sync (
        .i_mclk(i_mclk),
        .i_reset(i_reset),
        .i_async(i_wake),
        .o_sync(wake_s)
    );

    // misc async inputs: slow osc, reset pin, reset source, por
    // por is synced too: a runt pulse must not move the fsm half way
    // all four use the same agree-on-two-stages filter as the wake inputs
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            misc_s1_r <= 4'h0;
            misc_s2_r <= 4'h0;
            misc_s3_r <= 4'h0;
            misc_r <= 4'h0;
        end else begin
            misc_s1_r <= {i_por, i_any_reset_src, ~i_reset_pin_n, i_slow_osc};
            misc_s2_r <= misc_s1_r;
            misc_s3_r <= misc_s2_r;
            for (int k = 0; k < 4; k++) begin
                if (misc_s2_r[k] == misc_s3_r[k]) begin
                    misc_r[k] <= misc_s3_r[k];
                end
            end
        end
    end

    assign wake_hit = |wake_s;
    // a write lands on the edge where waitrequest is seen low, as the master expects
    assign wr = i_avs_write && ack_r;
    // read data is loaded one edge early so that it stands at the answer edge
    assign rd = i_avs_read && !ack_r;

    // one wait cycle per access, answer on the second edge; waitrequest is the inverse of ack_r
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (i_avs_read || i_avs_write) && !ack_r;
        end
    end

    // entry priority: shutdown, stop, suspend, snooze, idle
    // suspend and snooze also need the core clock on fast osc a
    always_comb begin
        mode_nxt = mode_r;
        case (mode_r)
            pmc_pkg::PMC_NORMAL: begin
                if (stop_req_r && deep_off_select_r) begin
                    mode_nxt = pmc_pkg::PMC_SHUTDOWN;
                end else if (stop_req_r) begin
                    mode_nxt = pmc_pkg::PMC_STOP;
                end else if (suspend_req_r && clk_fast_a_r) begin
                    mode_nxt = pmc_pkg::PMC_SUSPEND;
                end else if (snooze_req_r && clk_fast_a_r) begin
                    mode_nxt = pmc_pkg::PMC_SNOOZE;
                end else if (idle_req_r) begin
                    mode_nxt = pmc_pkg::PMC_IDLE;
                end
            end
            pmc_pkg::PMC_IDLE: begin
                if (i_irq_any) begin
                    mode_nxt = pmc_pkg::PMC_NORMAL;
                end
            end
            pmc_pkg::PMC_SUSPEND, pmc_pkg::PMC_SNOOZE: begin
                if (wake_hit) begin
                    mode_nxt = pmc_pkg::PMC_NORMAL;
                end
            end
            pmc_pkg::PMC_STOP: begin
                if (misc_r[2] || misc_r[1] || misc_r[3]) begin
                    mode_nxt = pmc_pkg::PMC_NORMAL;
                end
            end
            pmc_pkg::PMC_SHUTDOWN: begin
                if (misc_r[1] || misc_r[3]) begin
                    mode_nxt = pmc_pkg::PMC_NORMAL;
                end
            end
            default: mode_nxt = pmc_pkg::PMC_NORMAL;
        endcase
    end

    // leaving any low-power mode clears every request bit
    assign leave = (mode_r != pmc_pkg::PMC_NORMAL) && (mode_nxt == pmc_pkg::PMC_NORMAL);

    // reset pin / por cannot use the register file reset: caught by mode fsm instead
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            mode_r <= pmc_pkg::PMC_NORMAL;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    // request bits; hardware clear on exit wins over a software write
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            idle_req_r <= 1'b0;
            stop_req_r <= 1'b0;
            suspend_req_r <= 1'b0;
            snooze_req_r <= 1'b0;
        end else if (leave) begin
            idle_req_r <= 1'b0;
            stop_req_r <= 1'b0;
            suspend_req_r <= 1'b0;
            snooze_req_r <= 1'b0;
        end else if (wr && i_avs_byteenable[0]) begin
            if (i_avs_address == `PMC_OFF_CTL_A) begin
                idle_req_r <= i_avs_writedata[`PMC_BIT_IDLE];
                stop_req_r <= i_avs_writedata[`PMC_BIT_STOP];
            end
            if (i_avs_address == `PMC_OFF_CTL_B) begin
                suspend_req_r <= i_avs_writedata[`PMC_BIT_SUSPEND];
                snooze_req_r <= i_avs_writedata[`PMC_BIT_SNOOZE];
            end
        end
    end

    // suspend and snooze wait in normal until the core clock sits on fast osc a
    // regulator control: deep-off select and core clock source select
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            deep_off_select_r <= 1'b0;
            clk_fast_a_r <= 1'b0;
            pclk_r <= `PMC_PCLK_RESET;
        end else if (wr && i_avs_address == `PMC_OFF_REG) begin
            if (i_avs_byteenable[0]) begin
                deep_off_select_r <= i_avs_writedata[`PMC_BIT_DEEP_OFF];
                clk_fast_a_r <= i_avs_writedata[`PMC_BIT_CLK_FAST_A];
            end
            if (i_avs_byteenable[1]) begin
                pclk_r <= i_avs_writedata[15:8];
            end
        end
    end

    // status word: synced wake levels above the one-hot mode
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            o_avs_readdata <= 32'h0000_0000;
        end else if (rd) begin
            case (i_avs_address)
                `PMC_OFF_CTL_A: o_avs_readdata <= {30'h0, stop_req_r, idle_req_r};
                `PMC_OFF_CTL_B: o_avs_readdata <= {30'h0, snooze_req_r, suspend_req_r};
                `PMC_OFF_REG: o_avs_readdata <= {16'h0, pclk_r, 6'h0, clk_fast_a_r,
                    deep_off_select_r};
                `PMC_OFF_STATUS: o_avs_readdata <= {20'h0, wake_s, mode_r};
                default: o_avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            o_avs_waitrequest <= 1'b1;
        end else begin
            o_avs_waitrequest <= !((i_avs_read || i_avs_write) && !ack_r);
        end
    end

    // slow osc edge divided by eight; keeps counting through sleep
    // no tick while powered off; the divider simply pauses
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            slow_prev_r <= 1'b0;
            div_r <= 3'h0;
            o_timer_tick <= 1'b0;
        end else begin
            slow_prev_r <= misc_r[0];
            o_timer_tick <= 1'b0;
            if (misc_r[0] && !slow_prev_r && !o_power_off) begin
                div_r <= div_r + 3'h1;
                o_timer_tick <= (div_r == `PMC_DIV_SLOW);
            end
        end
    end

    // clock gates and oscillators follow mode_nxt so they switch with o_mode
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            o_core_clk_en <= 1'b1;
            o_periph_clk_en <= `PMC_PCLK_RESET;
            o_fast_osc_a_en <= 1'b1;
            o_fast_osc_b_en <= 1'b1;
        end else begin
            o_core_clk_en <= (mode_nxt == pmc_pkg::PMC_NORMAL);
            o_periph_clk_en <= fn_awake(mode_nxt) ? pclk_r : '0;
            o_fast_osc_a_en <= fn_awake(mode_nxt);
            o_fast_osc_b_en <= fn_awake(mode_nxt);
        end
    end

    // regulator bias and power switches; pins are held whenever nets are off
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            o_reg_low_bias <= 1'b0;
            o_power_off <= 1'b0;
            o_pin_hold <= 1'b0;
        end else begin
            o_reg_low_bias <= (mode_nxt == pmc_pkg::PMC_SNOOZE);
            o_power_off <= fn_off(mode_nxt);
            o_pin_hold <= fn_off(mode_nxt);
        end
    end

    // visible mode and wake arming
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            o_mode <= pmc_pkg::PMC_NORMAL;
            o_wake_sel <= 1'b0;
        end else begin
            o_mode <= mode_nxt;
            o_wake_sel <= fn_asleep(mode_nxt);
        end
    end
endmodule // pmc_top

// ===== tb/pmc_top_assertions.sv
// Purpose: port checks of the power mode controller
// Assumes: one clock, i_reset async high
// Notes: wake bounds allow for the input sync
`timescale 1ns/1ps
`include "pmc_defs.svh"
module pmc_top_assertions (
    input wire logic i_mclk, // clk
    input wire logic i_reset, // rst
    input wire logic i_irq_any, // irq
    input wire logic [`PMC_NUM_WAKE-1:0] i_wake, // wake
    input wire logic i_any_reset_src, // rst src
    input wire logic i_reset_pin_n, // pin
    input wire logic i_por, // por
    input wire logic o_core_clk_en, // core
    input wire logic [`PMC_NUM_PERIPH-1:0] o_periph_clk_en, // periph
    input wire logic o_fast_osc_a_en, // osc a
    input wire logic o_fast_osc_b_en, // osc b
    input wire logic o_reg_low_bias, // bias
    input wire logic o_power_off, // off
    input wire logic o_pin_hold, // hold
    input wire logic o_wake_sel, // armed
    input wire logic o_timer_tick, // tick
    input wire logic [5:0] o_mode // mode
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_reset);
    logic slp;
    logic off;
    assign slp = o_mode == pmc_pkg::PMC_SUSPEND || o_mode == pmc_pkg::PMC_SNOOZE;
    assign off = !o_core_clk_en && o_periph_clk_en == 8'h00 && !o_fast_osc_a_en
        && !o_fast_osc_b_en;
    property p_norm; o_mode == pmc_pkg::PMC_NORMAL |-> o_core_clk_en && !o_power_off; endproperty
    a_norm: assert property (p_norm) else $error("normal core off");
    property p_idle; o_mode == pmc_pkg::PMC_IDLE |-> !o_core_clk_en && o_fast_osc_a_en; endproperty
    a_idle: assert property (p_idle) else $error("idle clocks");
    property p_irq;
        o_mode == pmc_pkg::PMC_IDLE && i_irq_any |-> ##[1:3] o_mode == 6'h01;
    endproperty
    a_irq: assert property (p_irq) else $error("idle kept");
    property p_susp; o_mode == pmc_pkg::PMC_SUSPEND |-> off && !o_reg_low_bias; endproperty
    a_susp: assert property (p_susp) else $error("suspend outputs");
    property p_snz; o_mode == pmc_pkg::PMC_SNOOZE |-> off && o_reg_low_bias; endproperty
    a_snz: assert property (p_snz) else $error("snooze outputs");
    property p_wake; slp && |i_wake |-> o_wake_sel ##[1:8] o_mode == 6'h01; endproperty
    a_wake: assert property (p_wake) else $error("no wake");
    property p_tick; o_timer_tick |=> !o_timer_tick [*8]; endproperty
    a_tick: assert property (p_tick) else $error("tick too fast");
    property p_stop; o_mode == pmc_pkg::PMC_STOP |-> o_power_off && o_pin_hold; endproperty
    a_stop: assert property (p_stop) else $error("stop outputs");
    property p_stx; o_mode == 6'h10 && i_any_reset_src |-> ##[1:6] o_mode == 6'h01; endproperty
    a_stx: assert property (p_stx) else $error("stop kept");
    property p_shut;
        o_mode == 6'h20 |=> o_mode == 6'h20 && o_power_off || !i_reset_pin_n || i_por;
    endproperty
    a_shut: assert property (p_shut) else $error("shutdown left");
endmodule // pmc_top_assertions
bind pmc_top pmc_top_assertions i_pmc_top_assertions (.i_mclk, .i_reset, .i_irq_any, .i_wake,
    .i_any_reset_src, .i_reset_pin_n, .i_por, .o_core_clk_en, .o_periph_clk_en, .o_fast_osc_a_en,
    .o_fast_osc_b_en, .o_reg_low_bias, .o_power_off, .o_pin_hold, .o_wake_sel, .o_timer_tick,
    .o_mode);

// ===== tb/pmc_partner.sv
// Purpose: core and wake peripheral model
// Assumes: bench commands events
// Notes: events stay pending until serviced
`timescale 1ns/1ps
module pmc_partner (
    input wire logic i_mclk, // clk
    input wire logic i_irq_go, // raise irq
    input wire logic [5:0] i_wake_go, // raise wakes
    input wire logic i_core_clk_en, // core runs
    input wire logic i_wake_sel, // armed
    output logic o_irq_any, // irq
    output logic [5:0] o_wake, // wakes
    output logic o_slow_osc // slow osc
);
    initial begin
        o_slow_osc = 1'h0;
        forever #1370 o_slow_osc = ~o_slow_osc;
    end
    // irq pending until the core runs again
    always @(posedge i_mclk) o_irq_any <= i_irq_go || (o_irq_any && !i_core_clk_en);
    always @(posedge i_mclk) o_wake <= i_wake_go | (i_wake_sel ? o_wake : 6'h00);
endmodule // pmc_partner

// ===== tb/tb_top.sv
// Purpose: self-checking bench of the power mode controller
// Assumes: avalon-mm slave with one wait cycle
// Notes: read results checked from a queue
`timescale 1ns/1ps
module tb_top;
    logic i_mclk, i_reset, i_avs_read, i_avs_write, i_irq_any, i_any_reset_src, i_reset_pin_n;
    logic i_por, i_slow_osc, o_avs_waitrequest, o_core_clk_en, o_fast_osc_a_en, o_fast_osc_b_en;
    logic o_reg_low_bias, o_power_off, o_pin_hold, o_wake_sel, o_timer_tick, irq_go;
    logic [3:0] i_avs_address, i_avs_byteenable;
    logic [31:0] i_avs_writedata, o_avs_readdata, seed, exp_q[$];
    logic [5:0] i_wake, o_mode, wake_go;
    logic [7:0] o_periph_clk_en, pc;
    int n_errors, n_checks, n_tick, n_rise, t0, r0, i;
    pmc_top i_pmc_top (.i_mclk, .i_reset, .i_avs_address, .i_avs_read, .i_avs_write,
        .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .i_irq_any,
        .i_wake, .i_any_reset_src, .i_reset_pin_n, .i_por, .i_slow_osc, .o_core_clk_en,
        .o_periph_clk_en, .o_fast_osc_a_en, .o_fast_osc_b_en, .o_reg_low_bias, .o_power_off,
        .o_pin_hold, .o_wake_sel, .o_timer_tick, .o_mode);
    pmc_partner i_pmc_partner (.i_mclk, .i_irq_go(irq_go), .i_wake_go(wake_go),
        .i_core_clk_en(o_core_clk_en), .i_wake_sel(o_wake_sel), .o_irq_any(i_irq_any),
        .o_wake(i_wake), .o_slow_osc(i_slow_osc));
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic bus(input logic [3:0] a, input logic wr, input logic [31:0] d,
        input logic [3:0] be);
        @(posedge i_mclk);
        i_avs_address <= a;
        i_avs_write <= wr;
        i_avs_read <= !wr;
        i_avs_writedata <= d;
        i_avs_byteenable <= be;
        @(posedge i_mclk);
        while (o_avs_waitrequest !== 1'h0) @(posedge i_mclk);
        i_avs_write <= 1'h0;
        i_avs_read <= 1'h0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(a, 1'h0, 32'h0000_0000, 4'hf);
    endtask
    task automatic wmode(input logic [5:0] m);
        for (int j = 0; j < 40 && o_mode !== m; j++) @(posedge i_mclk);
        check("mode", o_mode, m);
    endtask
    task automatic pulse(input int w);
        for (int k = 1; k >= 0; k--) begin
            case (w)
                0: irq_go <= k[0];
                1: i_any_reset_src <= k[0];
                2: i_reset_pin_n <= !k[0];
                3: i_por <= k[0];
                default: i_reset <= k[0];
            endcase
            if (k == 1) repeat (8) @(posedge i_mclk);
        end
    endtask
    task automatic complete_run;
        if (n_errors == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge i_mclk) if (i_avs_read === 1'h1 && o_avs_waitrequest === 1'h0)
        check("readdata", o_avs_readdata, exp_q.pop_front());
    always @(posedge i_mclk) if (o_timer_tick === 1'h1) n_tick++;
    always @(posedge i_slow_osc) n_rise++;
    initial begin
        i_mclk = 1'h0;
        forever #25 i_mclk = ~i_mclk;
    end
    initial begin
        repeat (60000) @(posedge i_mclk);
        n_errors++;
        complete_run();
    end
    initial begin
        i_reset = 1'h1;
        {i_avs_read, i_avs_write, irq_go, i_any_reset_src, i_por} = 5'h00;
        {i_reset_pin_n, i_avs_address, i_avs_byteenable, wake_go} = 15'h43c0;
        i_avs_writedata = 32'h0000_0000;
        seed = 32'h0000_000c;
        repeat (6) @(posedge i_mclk);
        i_reset <= 1'h0;
        check("clocks", {o_core_clk_en, o_periph_clk_en, o_fast_osc_a_en}, 10'h3ff);
        check("off", o_power_off, 1'h0);
        {t0, r0} = {n_tick, n_rise};
        repeat (2000) @(posedge i_mclk);
        r0 = n_rise - r0;
        check("tick", (n_tick - t0) * 8 inside {[r0 - 16 : r0 + 8]}, 1'h1);
        rd(4'h8, 32'h0000_ff00);
        seed = xs(seed);
        pc = seed[7:0];
        bus(4'h8, 1'h1, {seed[31:16], pc, 8'h02}, 4'hf);
        repeat (2) @(posedge i_mclk);
        check("pclk", o_periph_clk_en, pc);
        bus(4'h8, 1'h1, 32'h0000_0002, 4'h1);
        rd(4'h8, {16'h0000, pc, 8'h02});
        bus(4'hc, 1'h1, 32'hffff_ffff, 4'hf);
        rd(4'hc, 32'h0000_0001);
        bus(4'h0, 1'h1, 32'h0000_0001, 4'hf);
        wmode(pmc_pkg::PMC_IDLE);
        check("idle", {o_core_clk_en, o_periph_clk_en}, {1'h0, pc});
        pulse(0);
        wmode(pmc_pkg::PMC_NORMAL);
        rd(4'h0, 32'h0000_0000);
        for (i = 0; i < 12; i++) begin
            bus(4'h4, 1'h1, (i < 6) ? 32'h0000_0001 : 32'h0000_0002, 4'hf);
            wmode((i < 6) ? pmc_pkg::PMC_SUSPEND : pmc_pkg::PMC_SNOOZE);
            check("sleep", {o_core_clk_en, o_fast_osc_b_en, o_reg_low_bias}, i > 5);
            wake_go <= 6'h01 << (i % 6);
            @(posedge i_mclk);
            wake_go <= 6'h00;
            wmode(pmc_pkg::PMC_NORMAL);
            rd(4'h4, 32'h0000_0000);
            repeat (8) @(posedge i_mclk);
        end
        bus(4'h8, 1'h1, {16'h0000, pc, 8'h02}, 4'hf);
        bus(4'h0, 1'h1, 32'h0000_0002, 4'hf);
        wmode(pmc_pkg::PMC_STOP);
        check("hold", {o_power_off, o_pin_hold}, 2'h3);
        pulse(1);
        wmode(pmc_pkg::PMC_NORMAL);
        for (i = 0; i < 2; i++) begin
            bus(4'h8, 1'h1, {16'h0000, pc, 8'h03}, 4'hf);
            bus(4'h0, 1'h1, 32'h0000_0002, 4'hf);
            wmode(pmc_pkg::PMC_SHUTDOWN);
            pulse(1);
            repeat (10) @(posedge i_mclk);
            check("mode", o_mode, pmc_pkg::PMC_SHUTDOWN);
            if (i == 0) pulse(2);
            else pulse(3);
            wmode(pmc_pkg::PMC_NORMAL);
        end
        pulse(4);
        @(posedge i_mclk);
        check("mode", o_mode, pmc_pkg::PMC_NORMAL);
        complete_run();
    end
endmodule // tb_top
